// ==== core/bbc_pkg.sv ====
package bbc_pkg;
    // dword addresses of the two configuration words held here
    localparam logic [7:0] DW_0C = 8'h0c;
    localparam logic [7:0] DW_18 = 8'h18;
    // byte offsets of each field
    localparam logic [7:0] OFF_LINE_SIZE = 8'h0c;
    localparam logic [7:0] OFF_UP_TIMER = 8'h0d;
    localparam logic [7:0] OFF_LAYOUT = 8'h0e;
    localparam logic [7:0] OFF_UP_BUS = 8'h18;
    localparam logic [7:0] OFF_DN_BUS = 8'h19;
    localparam logic [7:0] OFF_HIGH_BUS = 8'h1a;
    localparam logic [7:0] OFF_DN_TIMER = 8'h1b;
    // field bit positions inside a dword
    localparam int LINE_SIZE_LSB = 0;
    localparam int UP_TIMER_LSB = 8;
    localparam int LAYOUT_LSB = 16;
    localparam int UP_BUS_LSB = 0;
    localparam int DN_BUS_LSB = 8;
    localparam int HIGH_BUS_LSB = 16;
    localparam int DN_TIMER_LSB = 24;
    // reset and constant values
    localparam logic [7:0] RST_FIELD = 8'h00;
    localparam logic [7:0] LAYOUT_BRIDGE = 8'h01;
    localparam logic [7:0] LINE_SIZE_MAX = 8'h10;
    // decode result of a primary type 1 configuration
    typedef enum logic [1:0] {BBC_NO_CLAIM, BBC_TO_TYPE0, BBC_PASS_TYPE1} bbc_fwd_e;
endpackage

// ==== core/bbc_tenure_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// master tenure signals for one side of the bridge
interface bbc_tenure_if;
    logic [7:0] timer_val;
    logic frame_start;
    logic master_active;
    logic data_phase;
    logic grant;
    logic mwi;
    logic stop_req;
    logic expired;
    modport cfg (output timer_val, input stop_req, input expired);
    modport ctr (input timer_val, input frame_start, input master_active, input data_phase,
        input grant, input mwi, output stop_req, output expired);
    modport drv (output frame_start, output master_active, output data_phase, output grant,
        output mwi);
endinterface
`default_nettype wire

// ==== core/bbc_tenure.sv ====
`timescale 1ns/1ps
`default_nettype none
// latency timer of one master side
module bbc_tenure (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // tenure signals
    bbc_tenure_if.ctr ten
);
    typedef struct packed {
        logic [7:0] count;
        logic expired;
    } bbc_tenure_s;
    bbc_tenure_s st_q, st_d;

    // count clocks from frame assertion until the timer value is reached
    always_comb begin
        st_d = st_q;
        if (ten.frame_start) begin
            st_d.count = 8'h01;
            st_d.expired = (ten.timer_val <= 8'h01);
        end else if (ten.master_active && !st_q.expired) begin
            st_d.count = st_q.count + 8'h01;
            st_d.expired = (st_q.count + 8'h01 >= ten.timer_val);
        end else if (!ten.master_active) begin
            st_d.count = 8'h00;
            st_d.expired = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign ten.expired = st_q.expired || (ten.timer_val == 8'h00);
    // zero timer or expired timer: stop at a data phase once grant is gone, except mwi
    assign ten.stop_req = ten.master_active && ten.data_phase && !ten.grant && !ten.mwi
        && ten.expired;

    a_stop_needs_grant_off: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R15]
        ten.stop_req |-> !ten.grant && !ten.mwi) else $error("stop with grant or mwi");
    a_zero_timer_stops: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R6] [R8]
        (ten.timer_val == 8'h00 && ten.master_active && ten.data_phase && !ten.grant
        && !ten.mwi) |-> ten.stop_req) else $error("zero timer did not stop");
    a_expiry_waits: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R5] [R7]
        (ten.frame_start && ten.timer_val == 8'h04) ##1 ten.master_active [*2]
        |-> !ten.expired) else $error("timer expired early");
endmodule
`default_nettype wire

// ==== core/bbc_config_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (R1) line size is an 8-bit writable dword count at 0Ch that resets to zero.
// (R2) the usable line size sets prefetch length and where mwi bursts end.
// (R3) a line size that is not a power of two or is above 16 is treated as zero.
// (R4) software writes only power-of-two line sizes.
// (R5) the upstream timer is 8 writable bits at 0Dh, reset zero, counting from frame.
// (R6) with a zero upstream timer the bridge releases after one data phase once grant drops.
// (R7) the downstream timer is 8 writable bits at 1Bh, reset zero, counting from frame.
// (R8) with a zero downstream timer the bridge ends after one data phase once grant drops.
// (R9) the layout kind byte at 0Eh always reads 01h.
// (R10) the upstream bus index at 18h decides special cycle or upstream forwarding.
// (R11) the downstream bus index at 19h decides claiming and conversion to type 0.
// (R12) the highest bus below at 1Ah bounds type 1 pass-through with the downstream index.
// (R13) software sets the three bus indices before relying on forwarding.
// (R14) bus equal downstream goes type 0, above it up to highest passes type 1, else no claim.
// (R15) an expired nonzero timer ends the transfer at the next data phase once grant drops.
module bbc_config_regs (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // configuration access, type 0 on the upstream bus
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_dw_addr_i,
    input wire logic [3:0] cfg_be_n_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_hit_o,
    // downstream type 1 decode from the upstream side
    input wire logic [7:0] up_t1_bus_i,
    output bbc_pkg::bbc_fwd_e up_t1_fwd_o,
    // upstream forwarding check for type 1 seen downstream
    input wire logic [7:0] dn_t1_bus_i,
    output logic dn_t1_special_o,
    // line size use
    output logic [7:0] eff_line_size_o,
    output logic [7:0] prefetch_dwords_o,
    input wire logic [7:0] mwi_dword_idx_i,
    output logic mwi_line_end_o,
    // upstream master tenure
    input wire logic up_frame_start_i,
    input wire logic up_master_i,
    input wire logic up_data_phase_i,
    input wire logic up_grant_i,
    input wire logic up_mwi_i,
    output logic up_stop_o,
    output logic up_expired_o,
    // downstream master tenure
    input wire logic dn_frame_start_i,
    input wire logic dn_master_i,
    input wire logic dn_data_phase_i,
    input wire logic dn_grant_i,
    input wire logic dn_mwi_i,
    output logic dn_stop_o,
    output logic dn_expired_o
);
    typedef struct packed {
        logic [7:0] line_size;
        logic [7:0] up_timer;
        logic [7:0] up_bus;
        logic [7:0] dn_bus;
        logic [7:0] high_bus;
        logic [7:0] dn_timer;
        logic [31:0] rdata;
        logic hit;
    } bbc_regs_s;
    bbc_regs_s st_q, st_d;
    logic rst_n;
    logic [1:0] rst_sync_q; // kept apart: it resets on the raw pin, the fields on its copy
    logic sel_0c;
    logic sel_18;
    logic [7:0] ls;
    logic ls_ok;

    // reset release through two flip-flops
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign sel_0c = (cfg_dw_addr_i == bbc_pkg::DW_0C);
    assign sel_18 = (cfg_dw_addr_i == bbc_pkg::DW_18);

    // register writes per byte lane, reads registered
    always_comb begin
        st_d = st_q;
        st_d.hit = 1'b0;
        if (cfg_wr_i && sel_0c) begin
            if (!cfg_be_n_i[0]) begin
                st_d.line_size = cfg_wdata_i[bbc_pkg::LINE_SIZE_LSB +: 8]; // [R1]
            end
            if (!cfg_be_n_i[1]) begin
                st_d.up_timer = cfg_wdata_i[bbc_pkg::UP_TIMER_LSB +: 8]; // [R5]
            end
        end
        if (cfg_wr_i && sel_18) begin
            if (!cfg_be_n_i[0]) begin
                st_d.up_bus = cfg_wdata_i[bbc_pkg::UP_BUS_LSB +: 8]; // [R10]
            end
            if (!cfg_be_n_i[1]) begin
                st_d.dn_bus = cfg_wdata_i[bbc_pkg::DN_BUS_LSB +: 8]; // [R11]
            end
            if (!cfg_be_n_i[2]) begin
                st_d.high_bus = cfg_wdata_i[bbc_pkg::HIGH_BUS_LSB +: 8]; // [R12]
            end
            if (!cfg_be_n_i[3]) begin
                st_d.dn_timer = cfg_wdata_i[bbc_pkg::DN_TIMER_LSB +: 8]; // [R7]
            end
        end
        if (cfg_rd_i || cfg_wr_i) begin
            st_d.hit = sel_0c || sel_18;
        end
        if (cfg_rd_i) begin
            st_d.rdata = 32'h0000_0000;
            if (sel_0c) begin
                st_d.rdata[bbc_pkg::LINE_SIZE_LSB +: 8] = st_q.line_size;
                st_d.rdata[bbc_pkg::UP_TIMER_LSB +: 8] = st_q.up_timer;
                st_d.rdata[bbc_pkg::LAYOUT_LSB +: 8] = bbc_pkg::LAYOUT_BRIDGE; // [R9]
            end else if (sel_18) begin
                st_d.rdata[bbc_pkg::UP_BUS_LSB +: 8] = st_q.up_bus;
                st_d.rdata[bbc_pkg::DN_BUS_LSB +: 8] = st_q.dn_bus;
                st_d.rdata[bbc_pkg::HIGH_BUS_LSB +: 8] = st_q.high_bus;
                st_d.rdata[bbc_pkg::DN_TIMER_LSB +: 8] = st_q.dn_timer;
            end
        end
    end

    // field state, cleared to zero on reset
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            st_q.line_size <= bbc_pkg::RST_FIELD;
            st_q.up_timer <= bbc_pkg::RST_FIELD;
            st_q.up_bus <= bbc_pkg::RST_FIELD;
            st_q.dn_bus <= bbc_pkg::RST_FIELD;
            st_q.high_bus <= bbc_pkg::RST_FIELD;
            st_q.dn_timer <= bbc_pkg::RST_FIELD;
            st_q.rdata <= 32'h0000_0000;
            st_q.hit <= 1'b0;
        end else begin
            st_q.line_size <= st_d.line_size;
            st_q.up_timer <= st_d.up_timer;
            st_q.up_bus <= st_d.up_bus;
            st_q.dn_bus <= st_d.dn_bus;
            st_q.high_bus <= st_d.high_bus;
            st_q.dn_timer <= st_d.dn_timer;
            st_q.rdata <= st_d.rdata;
            st_q.hit <= st_d.hit;
        end
    end

    assign cfg_rdata_o = st_q.rdata;
    assign cfg_hit_o = st_q.hit;

    // usable line size: power of two not above 16, else zero
    assign ls = st_q.line_size;
    assign ls_ok = (ls != 8'h00) && ((ls & (ls - 8'h01)) == 8'h00)
        && (ls <= bbc_pkg::LINE_SIZE_MAX); // [R3]
    assign eff_line_size_o = ls_ok ? ls : 8'h00; // [R3]
    // prefetch one line, a single dword when no valid line size
    assign prefetch_dwords_o = ls_ok ? ls : 8'h01; // [R2]
    // mwi ends on the last dword of a line
    assign mwi_line_end_o = ls_ok
        && ((mwi_dword_idx_i & (ls - 8'h01)) == (ls - 8'h01)); // [R2]

    // type 1 decode against the bus indices
    always_comb begin
        up_t1_fwd_o = bbc_pkg::BBC_NO_CLAIM;
        if (up_t1_bus_i == st_q.dn_bus) begin
            up_t1_fwd_o = bbc_pkg::BBC_TO_TYPE0; // [R11] [R14]
        end else if (up_t1_bus_i > st_q.dn_bus && up_t1_bus_i <= st_q.high_bus) begin
            up_t1_fwd_o = bbc_pkg::BBC_PASS_TYPE1; // [R12] [R14]
        end
    end
    assign dn_t1_special_o = (dn_t1_bus_i == st_q.up_bus); // [R10]

    // tenure counters on both sides
    bbc_tenure_if up_if ();
    bbc_tenure_if dn_if ();
    assign up_if.timer_val = st_q.up_timer;
    assign up_if.frame_start = up_frame_start_i;
    assign up_if.master_active = up_master_i;
    assign up_if.data_phase = up_data_phase_i;
    assign up_if.grant = up_grant_i;
    assign up_if.mwi = up_mwi_i;
    assign dn_if.timer_val = st_q.dn_timer;
    assign dn_if.frame_start = dn_frame_start_i;
    assign dn_if.master_active = dn_master_i;
    assign dn_if.data_phase = dn_data_phase_i;
    assign dn_if.grant = dn_grant_i;
    assign dn_if.mwi = dn_mwi_i;

    bbc_tenure u_up_tenure (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n),
        .ten(up_if)
    );
    bbc_tenure u_dn_tenure (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n),
        .ten(dn_if)
    );
    assign up_stop_o = up_if.stop_req; // [R5] [R6] [R15]
    assign up_expired_o = up_if.expired;
    assign dn_stop_o = dn_if.stop_req; // [R7] [R8] [R15]
    assign dn_expired_o = dn_if.expired;

    a_layout_fixed: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // [R9]
        (cfg_rd_i && sel_0c) |=> cfg_rdata_o[23:16] == 8'h01) else $error("layout byte wrong");
    a_line_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // [R1]
        (cfg_wr_i && sel_0c && !cfg_be_n_i[0]) |=> st_q.line_size == $past(cfg_wdata_i[7:0]))
        else $error("line size not stored");
    a_bad_line_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // [R3]
        (st_q.line_size > 8'h10 || st_q.line_size == 8'h03) |-> eff_line_size_o == 8'h00)
        else $error("bad line size used");
    a_type0_decode: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // [R14]
        (up_t1_bus_i == st_q.dn_bus) |-> up_t1_fwd_o == bbc_pkg::BBC_TO_TYPE0)
        else $error("type 0 conversion missed");
    a_type1_range: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // [R12]
        (up_t1_fwd_o == bbc_pkg::BBC_PASS_TYPE1) |-> (up_t1_bus_i > st_q.dn_bus
        && up_t1_bus_i <= st_q.high_bus)) else $error("type 1 out of range");
    a_special_cycle: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // [R10]
        dn_t1_special_o |-> dn_t1_bus_i == st_q.up_bus) else $error("special cycle wrong");
    a_up_zero_stop: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // [R6]
        (st_q.up_timer == 8'h00 && up_master_i && up_data_phase_i && !up_grant_i && !up_mwi_i)
        |-> up_stop_o) else $error("upstream did not release");
    a_dn_mwi_exempt: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // [R8]
        dn_mwi_i |-> !dn_stop_o) else $error("mwi ended by timer");
    a_timer_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // [R7]
        (cfg_wr_i && sel_18 && !cfg_be_n_i[3]) |=> st_q.dn_timer
        == $past(cfg_wdata_i[31:24])) else $error("downstream timer not stored");
endmodule
`default_nettype wire

// ==== dv/bbc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// configuration master on the upstream bus, one access per call
module bbc_host_model (
    // clock
    input wire logic clk_i,
    // access strobes and payload
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] addr_o,
    output logic [3:0] be_n_o,
    output logic [31:0] wdata_o,
    // answer from the register bank
    input wire logic [31:0] rdata_i,
    input wire logic hit_i
);
    // idle bus at time zero
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        be_n_o = 4'hf;
        wdata_o = 32'h0;
    end

    // drive after a falling edge, hold over the taking edge, collect the answer a cycle on
    task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] b,
        input logic [31:0] d, output logic [31:0] q, output logic h);
        @(negedge clk_i);
        wr_o = wr;
        rd_o = ~wr;
        addr_o = a;
        be_n_o = b;
        wdata_o = d;
        @(negedge clk_i);
        wr_o = 1'b0;
        rd_o = 1'b0;
        q = rdata_i;
        h = hit_i;
        // payload is stale once the strobe drops, so scramble it
        addr_o = ~addr_o;
        be_n_o = ~be_n_o;
        wdata_o = ~wdata_o;
    endtask
endmodule
`default_nettype wire

// ==== dv/bridge_bus_config_header_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// register bank bench: config accesses, line size use, bus decode, master tenure
module bridge_bus_config_header_tb;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cfg_wr, cfg_rd, cfg_hit, h, dn_special, mwi_end;
    logic [7:0] cfg_addr, v, e, b;
    logic [7:0] up_bus = 8'h00;
    logic [7:0] dn_bus = 8'h00;
    logic [7:0] mwi_idx = 8'h00;
    logic [7:0] eff, pref;
    logic [3:0] be_n;
    logic [31:0] wdata, rdata, q;
    bbc_pkg::bbc_fwd_e fwd, ef;
    logic fs[2] = '{1'b0, 1'b0};
    logic ms[2] = '{1'b0, 1'b0};
    logic dp[2] = '{1'b0, 1'b0};
    logic gn[2] = '{1'b0, 1'b0};
    logic mw[2] = '{1'b0, 1'b0};
    logic stop[2], expd[2];
    logic [7:0] ls_tab[10] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h03, 8'h0c, 8'h20,
        8'hff};
    logic [7:0] bus_tab[6] = '{8'h02, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09};
    int fails = 0;
    int total_checks = 0;

    // 100 MHz clock
    always #5 clk_sys_i = ~clk_sys_i;

    bbc_host_model u_host (.clk_i(clk_sys_i), .wr_o(cfg_wr), .rd_o(cfg_rd), .addr_o(cfg_addr),
        .be_n_o(be_n), .wdata_o(wdata), .rdata_i(rdata), .hit_i(cfg_hit));

    bbc_config_regs u_dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd),
        .cfg_dw_addr_i(cfg_addr), .cfg_be_n_i(be_n), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata),
        .cfg_hit_o(cfg_hit), .up_t1_bus_i(up_bus), .up_t1_fwd_o(fwd), .dn_t1_bus_i(dn_bus),
        .dn_t1_special_o(dn_special), .eff_line_size_o(eff), .prefetch_dwords_o(pref),
        .mwi_dword_idx_i(mwi_idx), .mwi_line_end_o(mwi_end),
        .up_frame_start_i(fs[0]), .up_master_i(ms[0]), .up_data_phase_i(dp[0]),
        .up_grant_i(gn[0]), .up_mwi_i(mw[0]), .up_stop_o(stop[0]), .up_expired_o(expd[0]),
        .dn_frame_start_i(fs[1]), .dn_master_i(ms[1]), .dn_data_phase_i(dp[1]),
        .dn_grant_i(gn[1]), .dn_mwi_i(mw[1]), .dn_stop_o(stop[1]), .dn_expired_o(expd[1])
    );

    // compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // print counts and verdict, end the run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] bn, input logic [31:0] d);
        u_host.access(1'b1, a, bn, d, q, h);
    endtask

    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] ex,
        input logic eh);
        u_host.access(1'b0, a, 4'h0, 32'h0, q, h);
        check(n, q, ex);
        check({n, " hit"}, {31'h0, h}, {31'h0, eh});
    endtask

    // usable line size: power of two not above 16, else zero
    function automatic logic [7:0] ls_ok(input logic [7:0] x);
        return ((x & (x - 8'h01)) == 8'h00 && x <= 8'h10) ? x : 8'h00;
    endfunction

    // one master tenure with grant removed; timer already programmed to t
    task automatic tenure(input int s, input logic [7:0] t);
        logic z;
        z = (t == 8'h00);
        @(negedge clk_sys_i);
        fs[s] = 1'b1;
        ms[s] = 1'b1;
        dp[s] = 1'b1;
        @(negedge clk_sys_i);
        fs[s] = 1'b0;
        #1;
        check("early expired", {31'h0, expd[s]}, {31'h0, z});
        check("early stop", {31'h0, stop[s]}, {31'h0, z});
        repeat (3) @(negedge clk_sys_i);
        mw[s] = 1'b1;
        #1;
        check("mwi stop", {31'h0, stop[s]}, 32'h0);
        mw[s] = 1'b0;
        #1;
        check("late stop", {31'h0, stop[s]}, 32'h1);
        gn[s] = 1'b1;
        #1;
        check("granted stop", {31'h0, stop[s]}, 32'h0);
        gn[s] = 1'b0;
        ms[s] = 1'b0;
        dp[s] = 1'b0;
    endtask

    // main sequence
    initial begin
        repeat (3) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        rd_chk("dword 0c reset", 8'h0c, 32'h0001_0000, 1'b1);
        rd_chk("dword 18 reset", 8'h18, 32'h0, 1'b1);
        tenure(0, 8'h00);
        tenure(1, 8'h00);
        wr(8'h0c, 4'h0, 32'h007f_3308);
        rd_chk("dword 0c full", 8'h0c, 32'h0001_3308, 1'b1);
        wr(8'h18, 4'ha, 32'h4433_2211);
        wr(8'h18, 4'h5, 32'h8877_6655);
        rd_chk("dword 18 lanes", 8'h18, 32'h8833_6611, 1'b1);
        wr(8'h10, 4'h0, 32'hffff_ffff);
        rd_chk("unmapped", 8'h10, 32'h0, 1'b0);
        rd_chk("dword 0c kept", 8'h0c, 32'h0001_3308, 1'b1);
        foreach (ls_tab[i]) begin
            v = ls_tab[i];
            e = ls_ok(v);
            wr(8'h0c, 4'he, {24'h0, v});
            check("eff line size", {24'h0, eff}, {24'h0, e});
            check("prefetch", {24'h0, pref}, {24'h0, (e == 8'h00) ? 8'h01 : e});
            for (int k = 0; k < 2; k++) begin
                mwi_idx = v - 8'h01 + k[7:0];
                #1;
                check("mwi line end", {31'h0, mwi_end},
                    {31'h0, e != 8'h00 && (k == 0 || e == 8'h01)});
            end
        end
        wr(8'h0c, 4'hd, 32'h0000_0400);
        wr(8'h18, 4'h0, 32'h0408_0502);
        tenure(0, 8'h04);
        tenure(1, 8'h04);
        foreach (bus_tab[i]) begin
            b = bus_tab[i];
            up_bus = b;
            dn_bus = b;
            #1;
            ef = (b == 8'h05) ? bbc_pkg::BBC_TO_TYPE0 :
                (b > 8'h05 && b <= 8'h08) ? bbc_pkg::BBC_PASS_TYPE1 : bbc_pkg::BBC_NO_CLAIM;
            check("fwd", {30'h0, fwd}, {30'h0, ef});
            check("special", {31'h0, dn_special}, {31'h0, b == 8'h02});
        end
        give_verdict();
    end

    // watchdog well beyond the expected run length
    initial begin
        #200000;
        fails++;
        give_verdict();
    end
endmodule
`default_nettype wire
